// ===== rtl/strl_crc16.sv
// Word-wide CCITT checksum accumulator for the store check and store program.
module strl_crc16 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic feed,
    input wire logic [strl_pkg::WORD_W-1:0] word,
    output logic [strl_pkg::WORD_W-1:0] crc
);
    import strl_pkg::*;

    logic [WORD_W-1:0] crc_ff;
    logic [WORD_W-1:0] nxt_crc;

    // One whole word per cycle, most significant bit first, so a boot scan is short.
    always_comb begin
        nxt_crc = crc_ff;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            if (nxt_crc[WORD_W-1] ^ word[i]) begin
                nxt_crc = (nxt_crc << 1) ^ CRC_POLY;
            end else begin
                nxt_crc = nxt_crc << 1;
            end
        end
    end

    // Clear wins over feed so a new scan always starts from the seed.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_ff <= CRC_INIT;
        end else if (clear) begin
            crc_ff <= CRC_INIT;
        end else if (feed) begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;

endmodule // strl_crc16

// ===== rtl/strl_pkg.sv
// Shared constants and types of the serial target port with reset and map lock.
package strl_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int RW_BIT = 23;
    localparam int ADDR_HI = 22;
    localparam int ADDR_LO = 16;
    localparam int DATA_HI = 15;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 7;
    localparam logic [4:0] LAST_EDGE = 5'h17;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int REG_COUNT = 16;
    localparam int REG_AW = 4;
    localparam logic [6:0] ADDR_COMMON_CONFIG = 7'h01;
    localparam logic [6:0] ADDR_IF_CONFIG = 7'h02;
    localparam logic [6:0] ADDR_TRIGGER = 7'h03;
    localparam logic [6:0] ADDR_STATUS = 7'h04;
    localparam logic [6:0] ADDR_PIN_CONFIG = 7'h05;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Field positions.
    localparam int MAP_LOCK_BIT = 0;
    localparam int PIN_RESET_EN_BIT = 0;
    localparam int READOUT_PIN_ENABLE_BIT = 0;
    localparam int READOUT_EDGE_SELECT_BIT = 1;
    localparam int RESET_FIELD_LO = 0;
    localparam int PROGRAM_BIT = 4;
    localparam int UNLOCK_FIELD_LO = 12;
    localparam int STATUS_USER_FAIL_BIT = 0;
    localparam int STATUS_FACTORY_FAIL_BIT = 1;
    localparam int STATUS_BUSY_BIT = 2;

    // Trigger keys.
    localparam logic [3:0] RESET_KEY = 4'hA;
    localparam logic [3:0] UNLOCK_KEY = 4'h5;

    // ------------------------------------------------------------------
    // Store layout and checksum
    // ------------------------------------------------------------------
    localparam logic [3:0] USER_LAST_IDX = 4'h7;
    localparam logic [3:0] USER_CRC_IDX = 4'h8;
    localparam logic [3:0] FACTORY_CRC_IDX = 4'hD;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_CHECK = 2'b01,
        ST_READY = 2'b11,
        ST_PROG = 2'b10
    } strl_state_t;

    typedef enum logic [1:0] {
        HOST_NONE = 2'b00,
        HOST_SPI = 2'b01,
        HOST_I2C = 2'b10
    } strl_host_t;

endpackage

// ===== rtl/strl_spi_target.sv
// Serial target port with boot store check, software and pin reset, and map lock.
//
// Contract
// - Writing 1010 to the trigger reset field restarts boot and reloads defaults.
// - With pin reset enabled, a falling edge on the pin restarts boot.
// - A set map lock refuses register writes.
// - A software reset arriving from the I2C side works even when locked.
// - Writing key 0101 to the unlock field bypasses an active map lock.
// - Store program saves a checksum; boot recomputes and compares it.
// - Two store check flags, set only at boot, cleared only by reset.
// - A failed check loads factory defaults; registers stay readable and writable.
// - The first protocol heard after power-up owns the port until power cycle.
// - A frame starts on select low; input bits sampled on clock falling edges.
// - Frames ending with fewer than 24 falling edges are discarded.
// - Three-wire mode keeps only the first 24 bits of a long frame.
// - With select high, clock and input are blocked and output released.
// - Bit 23 read flag, bits 22-16 address, bits 15-0 data.
// - Output disabled after reset; readout enable bit selects four-wire mode.
// - The frame after a read shifts out echoed flag, address and data.
// - Readout edge select picks falling or rising clock edge for output.
// - Four-wire mode acts on last 24 bits only for multiples of 24.
module strl_spi_target (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spiSclk,
    input wire logic spiSelect_b,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOe,
    input wire logic resetPin_b,
    input wire logic i2cActive,
    input wire logic i2cTrigWr,
    input wire logic [strl_pkg::WORD_W-1:0] i2cTrigData,
    output logic [strl_pkg::REG_AW-1:0] nvmAddr,
    input wire logic [strl_pkg::WORD_W-1:0] nvmRdData,
    output logic nvmWrEn,
    output logic [strl_pkg::REG_AW-1:0] nvmWrAddr,
    output logic [strl_pkg::WORD_W-1:0] nvmWrData,
    output logic bootBusy,
    output logic userStoreCheckFail,
    output logic factoryStoreCheckFail,
    output logic mapLockActive,
    output logic hostIsSpi,
    output logic hostIsI2c
);
    import strl_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic sclkS1_ff, sclkS2_ff, sclkPrev_ff;
    logic selS1_ff, selS2_ff, selPrev_ff;
    logic sdiS1_ff, sdiS2_ff;
    logic pinS1_ff, pinS2_ff, pinPrev_ff;
    logic frameActive, frameStart, frameEnd, sclkFall, sclkRise;
    logic [FRAME_BITS-1:0] shift_ff;
    logic [4:0] edgeCnt_ff;
    logic fullSeen_ff;
    logic spiSdo_ff;
    logic [FRAME_BITS-1:0] echo_ff;
    logic [WORD_W-1:0] regs_ff [REG_COUNT];
    strl_state_t state_ff;
    strl_host_t host_ff;
    logic [REG_AW-1:0] idx_ff;
    logic userFail_ff, factoryFail_ff, unlock_ff;
    logic nvmWrEn_ff;
    logic [REG_AW-1:0] nvmWrAddr_ff;
    logic [WORD_W-1:0] nvmWrData_ff;
    logic fourWire, edgeSelRise, mapLock, frameValid, frameOk;
    logic isRead;
    logic [ADDR_W-1:0] fAddr;
    logic [WORD_W-1:0] fData;
    logic inMap, spiTrig, i2cTrig, softReset, pinReset, bootReq, progReq, spiWrite;
    logic [WORD_W-1:0] crc, crcWord, rdValue;
    logic crcClear, crcFeed;

    // ------------------------------------------------------------------
    // Synchronisers and edge detection
    // ------------------------------------------------------------------
    // Pins cross two flops; edges are found on the second stage only.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclkS1_ff <= 1'b0;
            sclkS2_ff <= 1'b0;
            sclkPrev_ff <= 1'b0;
            selS1_ff <= 1'b1;
            selS2_ff <= 1'b1;
            selPrev_ff <= 1'b1;
            sdiS1_ff <= 1'b0;
            sdiS2_ff <= 1'b0;
            pinS1_ff <= 1'b1;
            pinS2_ff <= 1'b1;
            pinPrev_ff <= 1'b1;
        end else begin
            sclkS1_ff <= spiSclk;
            sclkS2_ff <= sclkS1_ff;
            sclkPrev_ff <= sclkS2_ff;
            selS1_ff <= spiSelect_b;
            selS2_ff <= selS1_ff;
            selPrev_ff <= selS2_ff;
            sdiS1_ff <= spiSdi;
            sdiS2_ff <= sdiS1_ff;
            pinS1_ff <= resetPin_b;
            pinS2_ff <= pinS1_ff;
            pinPrev_ff <= pinS2_ff;
        end
    end

    // Clock edges only count while selected, so an idle bus is ignored.
    assign frameActive = !selS2_ff;
    assign frameStart = selPrev_ff && !selS2_ff;
    assign frameEnd = !selPrev_ff && selS2_ff;
    assign sclkFall = frameActive && sclkPrev_ff && !sclkS2_ff;
    assign sclkRise = frameActive && !sclkPrev_ff && sclkS2_ff;

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    assign fourWire = regs_ff[ADDR_IF_CONFIG[REG_AW-1:0]][READOUT_PIN_ENABLE_BIT];
    assign edgeSelRise = regs_ff[ADDR_IF_CONFIG[REG_AW-1:0]][READOUT_EDGE_SELECT_BIT];
    assign mapLock = regs_ff[ADDR_COMMON_CONFIG[REG_AW-1:0]][MAP_LOCK_BIT]
                     && !unlock_ff;

    // ------------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------------
    // One register both receives input and shifts out readback, which also
    // gives the chained pass-through delay of 24 bits for free.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_ff <= '0;
            edgeCnt_ff <= 5'h00;
            fullSeen_ff <= 1'b0;
        end else if (frameStart) begin
            shift_ff <= echo_ff;
            edgeCnt_ff <= 5'h00;
            fullSeen_ff <= 1'b0;
        end else if (sclkFall) begin
            if (!fullSeen_ff || fourWire) begin
                shift_ff <= {shift_ff[FRAME_BITS-2:0], sdiS2_ff};
            end
            if (edgeCnt_ff == LAST_EDGE) begin
                edgeCnt_ff <= 5'h00;
                fullSeen_ff <= 1'b1;
            end else begin
                edgeCnt_ff <= edgeCnt_ff + 5'h01;
            end
        end
    end

    // Short frames never set the full flag; four-wire also needs a whole multiple.
    assign frameValid = fullSeen_ff && (!fourWire || edgeCnt_ff == 5'h00);
    assign frameOk = frameEnd && frameValid && host_ff == HOST_SPI && state_ff == ST_READY;
    assign isRead = shift_ff[RW_BIT];
    assign fAddr = shift_ff[ADDR_HI:ADDR_LO];
    assign fData = shift_ff[DATA_HI:0];
    assign inMap = fAddr < ADDR_W'(REG_COUNT);

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    // First bit is presented at select; later bits on the chosen clock edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spiSdo_ff <= 1'b0;
        end else if (frameStart) begin
            spiSdo_ff <= echo_ff[RW_BIT];
        end else if (sclkFall && !edgeSelRise) begin
            spiSdo_ff <= shift_ff[FRAME_BITS-2];
        end else if (sclkRise && edgeSelRise) begin
            spiSdo_ff <= shift_ff[FRAME_BITS-1];
        end
    end

    assign spiSdo = spiSdo_ff;
    assign spiSdoOe = fourWire && frameActive && host_ff != HOST_I2C;

    // Readback value of a register, with read-only status and a write-only trigger.
    always_comb begin
        rdValue = REG_RESET;
        if (fAddr == ADDR_STATUS) begin
            rdValue[STATUS_USER_FAIL_BIT] = userFail_ff;
            rdValue[STATUS_FACTORY_FAIL_BIT] = factoryFail_ff;
            rdValue[STATUS_BUSY_BIT] = state_ff != ST_READY;
        end else if (inMap && fAddr != ADDR_TRIGGER) begin
            rdValue = regs_ff[fAddr[REG_AW-1:0]];
        end
    end

    // Every accepted frame is echoed in the next one; reads echo register data.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_ff <= '0;
        end else if (frameOk) begin
            echo_ff <= {isRead, fAddr, isRead ? rdValue : fData};
        end
    end

    // ------------------------------------------------------------------
    // Host selection
    // ------------------------------------------------------------------
    // Only power-on reset clears the owner; software resets leave it alone.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_ff <= HOST_NONE;
        end else if (host_ff == HOST_NONE) begin
            if (frameStart) begin
                host_ff <= HOST_SPI;
            end else if (i2cActive) begin
                host_ff <= HOST_I2C;
            end
        end
    end

    // ------------------------------------------------------------------
    // Trigger, lock and reset requests
    // ------------------------------------------------------------------
    assign spiTrig = frameOk && !isRead && fAddr == ADDR_TRIGGER;
    assign i2cTrig = i2cTrigWr && host_ff == HOST_I2C;
    assign softReset = (spiTrig && !mapLock && fData[RESET_FIELD_LO+:4] == RESET_KEY)
                       || (i2cTrig && i2cTrigData[RESET_FIELD_LO+:4] == RESET_KEY);
    assign pinReset = regs_ff[ADDR_PIN_CONFIG[REG_AW-1:0]][PIN_RESET_EN_BIT]
                      && pinPrev_ff && !pinS2_ff;
    assign bootReq = softReset || pinReset;
    assign progReq = state_ff == ST_READY && !mapLock
                     && ((spiTrig && fData[PROGRAM_BIT])
                     || (i2cTrig && i2cTrigData[PROGRAM_BIT]));
    // A locked write still ends the frame cleanly; it simply stores nothing.
    assign spiWrite = frameOk && !isRead && !mapLock && inMap
                      && fAddr != ADDR_TRIGGER && fAddr != ADDR_STATUS;

    // The unlock key is honoured while locked, otherwise it could never act.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            unlock_ff <= 1'b0;
        end else if (bootReq) begin
            unlock_ff <= 1'b0;
        end else if ((spiTrig && fData[UNLOCK_FIELD_LO+:4] == UNLOCK_KEY)
                     || (i2cTrig && i2cTrigData[UNLOCK_FIELD_LO+:4] == UNLOCK_KEY)) begin
            unlock_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Boot and program sequencer
    // ------------------------------------------------------------------
    // Store words 0-7 are user registers, 8 their checksum, 9-12 factory
    // words and 13 their checksum.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_LOAD;
            idx_ff <= '0;
        end else if (bootReq) begin
            state_ff <= ST_LOAD;
            idx_ff <= '0;
        end else begin
            case (state_ff)
                ST_LOAD: begin
                    if (idx_ff == FACTORY_CRC_IDX) begin
                        state_ff <= ST_CHECK;
                    end else begin
                        idx_ff <= idx_ff + 4'h1;
                    end
                end
                ST_CHECK: begin
                    state_ff <= ST_READY;
                    idx_ff <= '0;
                end
                ST_READY: begin
                    if (progReq) begin
                        state_ff <= ST_PROG;
                        idx_ff <= '0;
                    end
                end
                ST_PROG: begin
                    if (idx_ff == USER_CRC_IDX) begin
                        state_ff <= ST_READY;
                        idx_ff <= '0;
                    end else begin
                        idx_ff <= idx_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff <= ST_LOAD;
                    idx_ff <= '0;
                end
            endcase
        end
    end

    assign crcWord = state_ff == ST_PROG ? regs_ff[idx_ff] : nvmRdData;
    assign crcClear = bootReq || progReq || (state_ff == ST_LOAD && idx_ff == USER_CRC_IDX);
    assign crcFeed = (state_ff == ST_LOAD && idx_ff != USER_CRC_IDX && idx_ff != FACTORY_CRC_IDX)
                     || (state_ff == ST_PROG && idx_ff <= USER_LAST_IDX);

    strl_crc16 u_crc (
        .clk(clk),
        .rst_b(rst_b),
        .clear(crcClear),
        .feed(crcFeed),
        .word(crcWord),
        .crc(crc)
    );

    // Check flags are only set by the boot scan and only cleared by a reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            userFail_ff <= 1'b0;
            factoryFail_ff <= 1'b0;
        end else if (bootReq) begin
            userFail_ff <= 1'b0;
            factoryFail_ff <= 1'b0;
        end else if (state_ff == ST_LOAD && idx_ff == USER_CRC_IDX) begin
            userFail_ff <= crc != nvmRdData;
        end else if (state_ff == ST_LOAD && idx_ff == FACTORY_CRC_IDX) begin
            factoryFail_ff <= crc != nvmRdData;
        end
    end

    // Program writes are registered so address and data leave together.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nvmWrEn_ff <= 1'b0;
            nvmWrAddr_ff <= '0;
            nvmWrData_ff <= REG_RESET;
        end else begin
            nvmWrEn_ff <= state_ff == ST_PROG && !bootReq;
            nvmWrAddr_ff <= idx_ff;
            nvmWrData_ff <= idx_ff == USER_CRC_IDX ? crc : regs_ff[idx_ff];
        end
    end

    // ------------------------------------------------------------------
    // Register array
    // ------------------------------------------------------------------
    // Boot clears every word, then loads user words; a bad check wipes them
    // back to REG_RESET, yet later writes are accepted as usual.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_ff[i] <= REG_RESET;
            end
        end else if (bootReq) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_ff[i] <= REG_RESET;
            end
        end else if (state_ff == ST_LOAD && idx_ff <= USER_LAST_IDX) begin
            regs_ff[idx_ff] <= nvmRdData;
        end else if (state_ff == ST_CHECK && (userFail_ff || factoryFail_ff)) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_ff[i] <= REG_RESET;
            end
        end else if (spiWrite) begin
            regs_ff[fAddr[REG_AW-1:0]] <= fData;
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    assign nvmAddr = idx_ff;
    assign nvmWrEn = nvmWrEn_ff;
    assign nvmWrAddr = nvmWrAddr_ff;
    assign nvmWrData = nvmWrData_ff;
    assign bootBusy = state_ff != ST_READY;
    assign userStoreCheckFail = userFail_ff;
    assign factoryStoreCheckFail = factoryFail_ff;
    assign mapLockActive = mapLock;
    assign hostIsSpi = host_ff == HOST_SPI;
    assign hostIsI2c = host_ff == HOST_I2C;

endmodule // strl_spi_target

// ===== verification/strl_host_model.sv
// Serial host model that sends frames and captures the readout line.
module strl_host_model (
    input wire logic clk,
    input wire logic spiSdo,
    input wire logic spiSdoOe,
    output logic spiSclk,
    output logic spiSelect_b,
    output logic spiSdi,
    output logic [23:0] rxWord
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lastSdo = 1'b0;
    logic lineSdo;
    // A released line shows the inverse of its last level, so stale data cannot pass.
    always @(posedge clk) if (spiSdoOe) lastSdo <= spiSdo;
    assign lineSdo = spiSdoOe ? spiSdo : ~lastSdo;
    initial begin
        spiSclk = 1'b1;
        spiSelect_b = 1'b1;
        spiSdi = 1'b0;
        rxWord = '0;
    end
    // Half of the 80 ns link period.
    task automatic tick4;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Clock stands high outside frames; bits are sent from bit n-1 down.
    task automatic frame(input logic [47:0] bits, input int n);
        @(posedge clk) #1;
        spiSelect_b = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            spiSdi = bits[i];
            tick4;
            rxWord = {rxWord[22:0], lineSdo};
            spiSclk = 1'b0;
            tick4;
            spiSclk = 1'b1;
        end
        tick4;
        spiSelect_b = 1'b1;
        spiSdi = ~spiSdi;
        tick4;
    endtask
endmodule // strl_host_model

// ===== verification/strl_spi_target_sva.sv
// Concurrent checks on the pins of the serial target port.
module strl_spi_target_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spiSelect_b,
    input wire logic spiSdoOe,
    input wire logic nvmWrEn,
    input wire logic [strl_pkg::REG_AW-1:0] nvmWrAddr,
    input wire logic bootBusy,
    input wire logic userStoreCheckFail,
    input wire logic factoryStoreCheckFail,
    input wire logic hostIsSpi,
    input wire logic hostIsI2c
);
    timeunit 1ns;
    timeprecision 100ps;
    import strl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Enable follows the synchronised select, so three cycles of slack are allowed.
    oe_idle_a: assert property (spiSelect_b [*4] |-> !spiSdoOe)
        else $error("Output driven while select high");
    oe_owner_a: assert property (hostIsI2c |-> !spiSdoOe)
        else $error("Output driven while the other protocol owns the port");
    host_keep_a: assert property (hostIsSpi || hostIsI2c |=> $stable({hostIsSpi, hostIsI2c}))
        else $error("Host owner changed without power cycle");
    host_one_a: assert property (!(hostIsSpi && hostIsI2c))
        else $error("Two host owners at once");
    host_claim_a: assert property ($fell(spiSelect_b) ##5 1 |-> hostIsSpi || hostIsI2c)
        else $error("Select fall did not claim the port");
    flag_rise_a: assert property ($rose(userStoreCheckFail) || $rose(factoryStoreCheckFail)
        |-> $past(bootBusy))
        else $error("Check flag set outside boot");
    flag_hold_a: assert property (!bootBusy && !$past(bootBusy)
        |-> $stable(userStoreCheckFail) && $stable(factoryStoreCheckFail))
        else $error("Check flag changed outside boot or reset");
    wr_busy_a: assert property (nvmWrEn |-> $past(bootBusy) && nvmWrAddr <= USER_CRC_IDX)
        else $error("Store write outside program span");
    boot_span_a: assert property (!$past(rst_b) |-> bootBusy [*8])
        else $error("Boot check cut short");
endmodule // strl_spi_target_sva

bind strl_spi_target strl_spi_target_sva sva (.clk, .rst_b, .spiSelect_b, .spiSdoOe, .nvmWrEn,
    .nvmWrAddr, .bootBusy, .userStoreCheckFail, .factoryStoreCheckFail, .hostIsSpi, .hostIsI2c);

// ===== verification/tb_spi_target_with_reset_lock.sv
// Self-checking bench of the serial target port with reset and map lock.
module tb_spi_target_with_reset_lock;
    timeunit 1ns;
    timeprecision 100ps;
    import strl_pkg::*;
    logic clk = 1'b0;
    logic rst_b, resetPin_b, i2cActive, i2cTrigWr;
    logic [15:0] i2cTrigData, nvmRdData, nvmWrData;
    logic [3:0] nvmAddr, nvmWrAddr;
    logic spiSclk, spiSelect_b, spiSdi, spiSdo, spiSdoOe, nvmWrEn, bootBusy;
    logic userStoreCheckFail, factoryStoreCheckFail, mapLockActive, hostIsSpi, hostIsI2c;
    logic [15:0] store [16];
    logic [15:0] seed = 16'hFF29;
    int num_errors = 0;
    int compares = 0;
    strl_spi_target dut (.clk, .rst_b, .spiSclk, .spiSelect_b, .spiSdi, .spiSdo, .spiSdoOe,
        .resetPin_b, .i2cActive, .i2cTrigWr, .i2cTrigData, .nvmAddr, .nvmRdData, .nvmWrEn,
        .nvmWrAddr, .nvmWrData, .bootBusy, .userStoreCheckFail, .factoryStoreCheckFail,
        .mapLockActive, .hostIsSpi, .hostIsI2c);
    strl_host_model host (.clk, .spiSdo, .spiSdoOe, .spiSclk, .spiSelect_b, .spiSdi, .rxWord());
    // Store answers in the same cycle and keeps what is programmed.
    assign nvmRdData = store[nvmAddr];
    always @(posedge clk) if (nvmWrEn) store[nvmWrAddr] <= nvmWrData;
    initial forever #5 clk = ~clk;
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic logic [15:0] crc16(input int lo, input int hi);
        logic [15:0] c;
        c = CRC_INIT;
        for (int w = lo; w <= hi; w++)
            for (int b = 15; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ store[w][b]) ? CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic seal;
        store[USER_CRC_IDX] = crc16(0, 7);
        store[FACTORY_CRC_IDX] = crc16(9, 12);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.frame({25'h0, a, d}, 24);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        host.frame({24'h0, 1'b1, a, 16'h0000}, 24);
        host.frame(48'h0, 24);
        check(host.rxWord, {1'b1, a, exp});
    endtask
    task automatic waitReady;
        for (int i = 0; i < 200 && bootBusy !== 1'b0; i++) @(posedge clk);
        #1;
        if (bootBusy !== 1'b0) num_errors++;
    endtask
    task automatic softReset;
        wr(ADDR_TRIGGER, {12'h000, RESET_KEY});
        check(bootBusy, 1'b1);
        waitReady;
    endtask
    task automatic wrap_up;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #500us;
        num_errors++;
        wrap_up;
    end
    initial begin
        logic [15:0] d, e;
        {rst_b, resetPin_b, i2cActive, i2cTrigWr, i2cTrigData} = {4'b0100, 16'h0000};
        for (int i = 0; i < 16; i++) store[i] = rnd() & 16'h0FE0;
        store[1] = 16'h0000;
        store[5] = 16'h0001;
        seal;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        waitReady;
        check({userStoreCheckFail, factoryStoreCheckFail}, 0);
        wr(ADDR_IF_CONFIG, 16'h0001);
        rdchk(7'h06, store[6]);
        // Both readout edges, fresh random data each time.
        for (int m = 0; m < 2; m++) begin
            d = rnd();
            wr(ADDR_IF_CONFIG, {14'h0, m[0], 1'b1});
            wr(7'h06, d);
            rdchk(7'h06, d);
        end
        host.frame({25'h0, 7'h06, ~d} >> 1, 23);
        rdchk(7'h06, d);
        e = rnd();
        host.frame({8'h06, ~d, 8'h06, e}, 48);
        rdchk(7'h06, e);
        host.frame({18'h0, 8'h06, ~e, 6'h15}, 30);
        rdchk(7'h06, e);
        d = rnd();
        wr(ADDR_IF_CONFIG, 16'h0000);
        host.frame({18'h0, 8'h06, d, 6'h2A}, 30);
        wr(ADDR_IF_CONFIG, 16'h0001);
        rdchk(7'h06, d);
        wr(ADDR_COMMON_CONFIG, 16'h0001);
        check(mapLockActive, 1'b1);
        wr(7'h06, ~d);
        rdchk(7'h06, d);
        wr(ADDR_TRIGGER, {UNLOCK_KEY, 12'h000});
        check(mapLockActive, 1'b0);
        e = rnd();
        wr(7'h06, e);
        wr(ADDR_COMMON_CONFIG, 16'h0000);
        wr(ADDR_TRIGGER, 16'h0010);
        waitReady;
        check({store[6], store[8]}, {e, crc16(0, 7)});
        wr(7'h06, ~e);
        softReset;
        wr(ADDR_IF_CONFIG, 16'h0001);
        rdchk(7'h06, e);
        // Pin reset acts on the fall only.
        resetPin_b = 1'b0;
        repeat (10) @(posedge clk);
        check(bootBusy, 1'b1);
        waitReady;
        resetPin_b = 1'b1;
        repeat (10) @(posedge clk);
        check(bootBusy, 1'b0);
        store[0] ^= 16'h8000;
        softReset;
        check({userStoreCheckFail, factoryStoreCheckFail}, 2'b10);
        wr(ADDR_IF_CONFIG, 16'h0001);
        rdchk(7'h06, 16'h0000);
        wr(7'h06, d);
        rdchk(7'h06, d);
        store[0] ^= 16'h8000;
        store[10] ^= 16'h0001;
        softReset;
        check({userStoreCheckFail, factoryStoreCheckFail}, 2'b01);
        store[10] ^= 16'h0001;
        store[1] = 16'h0001;
        seal;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 {rst_b, i2cActive} = 2'b11;
        @(posedge clk) #1 i2cActive = 1'b0;
        waitReady;
        wr(7'h06, d);
        check({hostIsI2c, hostIsSpi, mapLockActive}, 3'b101);
        {i2cTrigWr, i2cTrigData} = {1'b1, 12'h000, RESET_KEY};
        @(posedge clk) #1 i2cTrigWr = 1'b0;
        repeat (3) @(posedge clk);
        check(bootBusy, 1'b1);
        wrap_up;
    end
endmodule // tb_spi_target_with_reset_lock
